// >>> design/usbpi_pkg.sv
// Package: register map, field positions, timing constants and carriers for USB power/flags
package usbpi_pkg;

  // Register byte offsets on the plain register port
  localparam logic [7:0] OFF_POWER_CONTROL = 8'h00;   // usb_power_control
  localparam logic [7:0] OFF_INT_FLAGS     = 8'h04;   // usb_interrupt_flags
  localparam logic [7:0] OFF_INT_ENABLE    = 8'h08;   // per-flag interrupt enables
  localparam logic [7:0] OFF_ERR_ENABLE    = 8'h0C;   // error_enable_register
  localparam logic [7:0] OFF_ERR_STATUS    = 8'h10;   // individual error flags, write 1 to clear
  localparam logic [7:0] OFF_ROLE_CONTROL  = 8'h14;   // host_role_enable in bit 0

  // Power-control field positions
  localparam int PWR_ENABLE_BIT   = 0;
  localparam int PWR_SUSPEND_BIT  = 1;
  localparam int PWR_NOT_RDY_BIT  = 3;
  localparam int PWR_GUARD_BIT    = 4;
  localparam int PWR_ACT_PND_BIT  = 7;

  // Interrupt-flag field positions
  localparam int FLG_RESET_DETACH = 0;
  localparam int FLG_ERROR        = 1;
  localparam int FLG_FRAME_START  = 2;
  localparam int FLG_TOKEN_DONE   = 3;
  localparam int FLG_IDLE         = 4;
  localparam int FLG_RESUME       = 5;
  localparam int FLG_ATTACH       = 6;
  localparam int FLG_STALL        = 7;

  // Values after reset
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // Clock and documented times
  localparam int CLK_PERIOD_NS    = 100;
  localparam int LINE_TIME_NS     = 2500;   // resume K, attach quiet, detach/reset SE0
  localparam int IDLE_TIME_MS     = 3;
  localparam int BUSY_TIME_NS     = 1000;   // settle time after disable
  localparam int LINE_CYC = (LINE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_CYC_DEF =
    (IDLE_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_CYC = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Line state, one-hot
  typedef enum logic [3:0] {
    LS_SE0 = 4'b0001,
    LS_J   = 4'b0010,
    LS_K   = 4'b0100,
    LS_SE1 = 4'b1000
  } usbpi_line_t;

  // Events from the packet engine, same clock
  typedef struct packed {
    logic       stall_handshake;   // STALL seen (host) or sent (device) in handshake phase
    logic       token_done;        // current token finished
    logic       frame_start;       // SOF received or SOF threshold reached
    logic [7:0] error_events;      // individual error conditions
  } usbpi_evt_t;

  // Power controls toward clock gate, transceiver and pads
  typedef struct packed {
    logic usb_clk_enable;      // 48 MHz clock gate
    logic xcvr_low_power;
    logic pins_owned;
    logic analog_on;
  } usbpi_phy_t;

endpackage : usbpi_pkg

// >>> design/usbpi_power_flags.sv
// USB power-control and interrupt-flag logic with its register port
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module usbpi_power_flags #(
  parameter int IDLE_CYC = usbpi_pkg::IDLE_CYC_DEF
) (
  input  wire logic                ref_clk,
  input  wire logic                reset_n,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [31:0]         reg_wdata,
  input  wire logic                reg_write,
  input  wire logic                reg_read,
  output logic      [31:0]         reg_rdata,
  input  wire logic                usb_dp,
  input  wire logic                usb_dm,
  input  wire usbpi_pkg::usbpi_evt_t engine_evt,
  output usbpi_pkg::usbpi_phy_t    phy_ctrl,
  output logic                     host_role_enable,
  output logic                     sleep_block,
  output logic                     combined_interrupt_request,
  output logic                     token_fifo_advance
);
  import usbpi_pkg::*;

  // All state of the block
  typedef struct packed {
    logic [1:0]  dp_sync;
    logic [1:0]  dm_sync;
    usbpi_line_t line;
    logic [15:0] line_cnt;
    logic        module_enable;
    logic        suspend_request;
    logic        sleep_guard;
    logic [3:0]  busy_cnt;
    logic        activity_pending;
    logic        host_role;
    logic        attached;
    logic [7:0]  flags;
    logic [7:0]  int_enable;
    logic [7:0]  err_enable;
    logic [7:0]  err_status;
    logic        fifo_adv;
    logic [31:0] rdata;
  } usbpi_state_t;

  usbpi_state_t s_q;
  usbpi_state_t s_d;

  // Address match, shared by read and write decode
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction : hit

  // Line state from the synchronised pins (full-speed polarity)
  function automatic usbpi_line_t decode_line(input logic dp, input logic dm);
    usbpi_line_t ls;
    ls = LS_SE1;
    if (!dp && !dm) begin
      ls = LS_SE0;
    end else if (dp && !dm) begin
      ls = LS_J;
    end else if (!dp && dm) begin
      ls = LS_K;
    end
    decode_line = ls;
  endfunction : decode_line

  logic [15:0] line_thr;
  logic [15:0] idle_thr;
  logic [3:0]  busy_init;
  assign line_thr  = 16'(LINE_CYC);
  assign idle_thr  = 16'(IDLE_CYC);
  assign busy_init = 4'(BUSY_CYC);

  // Combinational intermediates
  usbpi_line_t ls_now;
  logic        wr_pwr;
  logic        wr_flg;
  logic        wr_ie;
  logic        wr_ee;
  logic        wr_es;
  logic        wr_role;
  logic        stable;
  logic        line_hit;
  logic        idle_hit;
  logic        activity;
  logic        err_summary;
  logic [7:0]  flag_view;
  logic [7:0]  set_mask;
  logic [7:0]  clr_mask;
  logic [7:0]  pwr_view;

  always_comb begin
    ls_now   = decode_line(s_q.dp_sync[1], s_q.dm_sync[1]);
    wr_pwr   = reg_write && hit(reg_addr, OFF_POWER_CONTROL);
    wr_flg   = reg_write && hit(reg_addr, OFF_INT_FLAGS);
    wr_ie    = reg_write && hit(reg_addr, OFF_INT_ENABLE);
    wr_ee    = reg_write && hit(reg_addr, OFF_ERR_ENABLE);
    wr_es    = reg_write && hit(reg_addr, OFF_ERR_STATUS);
    wr_role  = reg_write && hit(reg_addr, OFF_ROLE_CONTROL);
    stable   = (ls_now == s_q.line);
    // Threshold crossings fire once, on the edge the count reaches them
    line_hit = stable && (s_q.line_cnt == line_thr - 16'h0001);
    idle_hit = stable && (s_q.line_cnt == idle_thr - 16'h0001);
    activity = s_q.module_enable && !stable;
    err_summary = |(s_q.err_status & s_q.err_enable);
    flag_view = s_q.flags;
    flag_view[FLG_ERROR] = err_summary;
    pwr_view = RST_BYTE;
    pwr_view[PWR_ENABLE_BIT]  = s_q.module_enable;
    pwr_view[PWR_SUSPEND_BIT] = s_q.suspend_request;
    pwr_view[PWR_NOT_RDY_BIT] = s_q.module_enable || (s_q.busy_cnt != 4'h0);
    pwr_view[PWR_GUARD_BIT]   = s_q.sleep_guard;
    pwr_view[PWR_ACT_PND_BIT] = s_q.activity_pending;

    // Hardware set events; nothing is flagged while the module is off
    set_mask = RST_BYTE;
    if (s_q.module_enable) begin
      set_mask[FLG_STALL]       = engine_evt.stall_handshake && !s_q.suspend_request;
      set_mask[FLG_TOKEN_DONE]  = engine_evt.token_done && !s_q.suspend_request;
      set_mask[FLG_FRAME_START] = engine_evt.frame_start && !s_q.suspend_request;
      set_mask[FLG_RESUME]      = line_hit && (s_q.line == LS_K);
      set_mask[FLG_IDLE]        = idle_hit && (s_q.line == LS_J);
      set_mask[FLG_ATTACH]      = s_q.host_role && !s_q.attached && line_hit &&
                                  (s_q.line != LS_SE0);
      if (s_q.host_role) begin
        set_mask[FLG_RESET_DETACH] = s_q.attached && line_hit && (s_q.line == LS_SE0);
      end else begin
        set_mask[FLG_RESET_DETACH] = line_hit && (s_q.line == LS_SE0);
      end
    end
    // Write 1 clears; error summary bit is not writable
    clr_mask = wr_flg ? reg_wdata[7:0] : RST_BYTE;
    clr_mask[FLG_ERROR] = 1'b0;

    s_d = s_q;

    // Two-flop synchronisers on the data-line pins
    s_d.dp_sync = {s_q.dp_sync[0], usb_dp};
    s_d.dm_sync = {s_q.dm_sync[0], usb_dm};

    // Line-state stability counter, saturating at the idle threshold
    s_d.line = ls_now;
    if (!stable) begin
      s_d.line_cnt = 16'h0000;
    end else if (s_q.line_cnt < idle_thr) begin
      s_d.line_cnt = s_q.line_cnt + 16'h0001;
    end

    // Power-control writes; status bits are read-only
    if (wr_pwr) begin
      s_d.module_enable   = reg_wdata[PWR_ENABLE_BIT];
      s_d.suspend_request = reg_wdata[PWR_SUSPEND_BIT];
      s_d.sleep_guard     = reg_wdata[PWR_GUARD_BIT];
    end

    // Settle time after disable keeps not-ready high
    if (s_q.module_enable && !s_d.module_enable) begin
      s_d.busy_cnt = busy_init;
    end else if (s_q.busy_cnt != 4'h0) begin
      s_d.busy_cnt = s_q.busy_cnt - 4'h1;
    end

    // Activity while suspended is pending until the resume flag is raised
    if (!s_q.module_enable || !s_q.suspend_request) begin
      s_d.activity_pending = 1'b0;
    end else if (activity) begin
      s_d.activity_pending = 1'b1;
    end else if (set_mask[FLG_RESUME]) begin
      s_d.activity_pending = 1'b0;
    end

    // Attachment tracking for the host-role detach flag
    if (!s_q.host_role || !s_q.module_enable) begin
      s_d.attached = 1'b0;
    end else if (set_mask[FLG_ATTACH]) begin
      s_d.attached = 1'b1;
    end else if (set_mask[FLG_RESET_DETACH]) begin
      s_d.attached = 1'b0;
    end

    // Set wins over a clear in the same cycle
    s_d.flags = (s_q.flags & ~clr_mask) | set_mask;
    s_d.flags[FLG_ERROR] = 1'b0;

    // Token FIFO advances when software clears a set token flag
    s_d.fifo_adv = wr_flg && reg_wdata[FLG_TOKEN_DONE] && s_q.flags[FLG_TOKEN_DONE];

    // Enables and individual errors
    if (wr_ie) begin
      s_d.int_enable = reg_wdata[7:0];
    end
    if (wr_ee) begin
      s_d.err_enable = reg_wdata[7:0];
    end
    if (wr_role) begin
      s_d.host_role = reg_wdata[0];
    end
    s_d.err_status = (s_q.err_status & ~(wr_es ? reg_wdata[7:0] : RST_BYTE)) |
                     (s_q.module_enable ? engine_evt.error_events : RST_BYTE);

    // Read data, presented one cycle after the strobe; unmapped reads 0
    s_d.rdata = RST_WORD;
    if (reg_read) begin
      if (hit(reg_addr, OFF_POWER_CONTROL)) begin
        s_d.rdata = {24'h00_0000, pwr_view};
      end else if (hit(reg_addr, OFF_INT_FLAGS)) begin
        s_d.rdata = {24'h00_0000, flag_view};
      end else if (hit(reg_addr, OFF_INT_ENABLE)) begin
        s_d.rdata = {24'h00_0000, s_q.int_enable};
      end else if (hit(reg_addr, OFF_ERR_ENABLE)) begin
        s_d.rdata = {24'h00_0000, s_q.err_enable};
      end else if (hit(reg_addr, OFF_ERR_STATUS)) begin
        s_d.rdata = {24'h00_0000, s_q.err_status};
      end else if (hit(reg_addr, OFF_ROLE_CONTROL)) begin
        s_d.rdata = {31'h0000_0000, s_q.host_role};
      end
    end
  end

  // Single state register; reset loads constants only
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '{dp_sync: 2'b00, dm_sync: 2'b00, line: LS_SE0, line_cnt: 16'h0000,
               module_enable: 1'b0, suspend_request: 1'b0, sleep_guard: 1'b0,
               busy_cnt: 4'h0, activity_pending: 1'b0, host_role: 1'b0,
               attached: 1'b0, flags: RST_BYTE, int_enable: RST_BYTE,
               err_enable: RST_BYTE, err_status: RST_BYTE, fifo_adv: 1'b0,
               rdata: RST_WORD};
    end else begin
      s_q <= s_d;
    end
  end

  // Power controls; disabled module holds everything inactive
  assign phy_ctrl.usb_clk_enable = s_q.module_enable && !s_q.suspend_request;
  assign phy_ctrl.xcvr_low_power = !s_q.module_enable || s_q.suspend_request;
  assign phy_ctrl.pins_owned     = s_q.module_enable;
  assign phy_ctrl.analog_on      = s_q.module_enable;

  // Error summary reaches the request only through its own enable
  assign combined_interrupt_request = s_q.module_enable &&
                                      (|(flag_view & s_q.int_enable));

  // Guard blocks sleep on activity or any pending flag whose interrupt enable is set
  assign sleep_block = s_q.sleep_guard && s_q.module_enable &&
                       (s_q.activity_pending || activity ||
                        (|(flag_view & s_q.int_enable)));

  assign host_role_enable   = s_q.host_role;
  assign token_fifo_advance = s_q.fifo_adv;
  assign reg_rdata          = s_q.rdata;

endmodule : usbpi_power_flags

`default_nettype wire

// >>> testbench/test_usb_power_and_interrupt_flags.sv
// Testbench: register, event and line scenarios against a reference model
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module test_usb_power_and_interrupt_flags;
  import usbpi_pkg::*;
  logic        ref_clk, reset_n, reg_write, reg_read, usb_dp, usb_dm, host_role_enable;
  logic        sleep_block, combined_interrupt_request, token_fifo_advance, act, busy;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed;
  usbpi_evt_t  engine_evt;
  usbpi_phy_t  phy_ctrl;
  usbpi_line_t line_cmd;
  int          n_fail, checks_done, cyc, k, m[6], fb[3];
  usbpi_power_flags #(.IDLE_CYC(60)) u_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .usb_dp(usb_dp), .usb_dm(usb_dm), .engine_evt(engine_evt),
    .phy_ctrl(phy_ctrl), .host_role_enable(host_role_enable), .sleep_block(sleep_block),
    .combined_interrupt_request(combined_interrupt_request),
    .token_fifo_advance(token_fifo_advance));
  usbpi_line_model u_line (.ref_clk(ref_clk), .line_cmd(line_cmd), .usb_dp(usb_dp),
    .usb_dm(usb_dm));
  // Clock and hang guard; a normal run needs about five hundred cycles
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      complete_run();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Model view of a register read; status bits come from bench state
  function automatic logic [31:0] expv(input logic [7:0] a);
    logic [31:0] v;
    v = (a < 8'h18 && a[1:0] == 2'b00) ? m[a >> 2] : 0;
    if (a == OFF_POWER_CONTROL) v[3] = v[0] | busy;
    if (a == OFF_POWER_CONTROL) v[7] = act;
    if (a == OFF_INT_FLAGS) v[1] = |(m[3] & m[4]);
    return v;
  endfunction : expv
  // Upper write bits are random junk that must be ignored
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d | (rnd() & 32'hFFFF_FF00);
    @(posedge ref_clk);
    reg_write <= 1'b0;
    case (a)
      OFF_POWER_CONTROL: m[0] = d & 8'h13;
      OFF_INT_FLAGS:     m[1] = m[1] & ~d & 8'hFD;
      OFF_INT_ENABLE:    m[2] = d & 8'hFF;
      OFF_ERR_ENABLE:    m[3] = d & 8'hFF;
      OFF_ERR_STATUS:    m[4] = m[4] & ~d;
      OFF_ROLE_CONTROL:  m[5] = d & 8'h01;
      default: ;
    endcase
  endtask : wr
  task automatic rc(input logic [7:0] a);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 `CHK(reg_rdata, expv(a))
  endtask : rc
  task automatic ev(input usbpi_evt_t e, input int b);
    @(posedge ref_clk);
    engine_evt <= e;
    @(posedge ref_clk);
    engine_evt <= '0;
    if (b >= 0) m[1][b] = 1'b1;
    m[4] = m[4] | e.error_events;
  endtask : ev
  task automatic ln(input usbpi_line_t s, input int n, input int b);
    line_cmd <= s;
    repeat (n) @(posedge ref_clk);
    if (b >= 0) m[1][b] = 1'b1;
  endtask : ln
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  initial begin
    seed = 32'h0000_b8cd;
    {reset_n, reg_write, reg_read, act, busy, reg_addr, reg_wdata} = '0;
    engine_evt = '0;
    line_cmd = LS_J;
    fb = '{7, 3, 2};
    foreach (m[i]) m[i] = 0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int a = 0; a <= 24; a += 4) rc(8'(a));
    wr(OFF_POWER_CONTROL, 8'h11);
    rc(OFF_POWER_CONTROL);
    `CHK(phy_ctrl, 4'b1011)
    repeat (80) @(posedge ref_clk);
    wr(OFF_INT_FLAGS, 8'hFF);
    $display("reset and enable done");
    // Engine events: set, read, clear by writing one
    for (k = 0; k < 3; k++) begin
      ev(usbpi_evt_t'(11'h400 >> k), fb[k]);
      rc(OFF_INT_FLAGS);
      wr(OFF_INT_FLAGS, 32'(1) << fb[k]);
      #1 `CHK(token_fifo_advance, k == 1)
      rc(OFF_INT_FLAGS);
    end
    // Hardware set and software clear land in one cycle
    @(posedge ref_clk);
    reg_write  <= 1'b1;
    reg_addr   <= OFF_INT_FLAGS;
    reg_wdata  <= 32'h0000_0008;
    engine_evt <= usbpi_evt_t'(11'h200);
    @(posedge ref_clk);
    reg_write  <= 1'b0;
    engine_evt <= '0;
    m[1][3] = 1'b1;
    rc(OFF_INT_FLAGS);
    wr(OFF_INT_FLAGS, 8'h08);
    $display("event flags done");
    // Error summary: masked first, then enabled, then cleared at the source
    k = rnd() & 7;
    ev(usbpi_evt_t'(11'(1) << k), -1);
    rc(OFF_INT_FLAGS);
    rc(OFF_ERR_STATUS);
    wr(OFF_ERR_ENABLE, 32'(1) << k);
    wr(OFF_INT_ENABLE, 8'h02);
    rc(OFF_INT_FLAGS);
    `CHK(combined_interrupt_request, 1'b1)
    wr(OFF_INT_ENABLE, 8'h00);
    #1 `CHK(combined_interrupt_request, 1'b0)
    wr(OFF_INT_FLAGS, 8'h02);
    rc(OFF_INT_FLAGS);
    wr(OFF_ERR_STATUS, 32'(1) << k);
    rc(OFF_INT_FLAGS);
    $display("error summary done");
    // Device line events, then host attach and detach
    ln(LS_SE0, 35, FLG_RESET_DETACH);
    ln(LS_K, 35, FLG_RESUME);
    ln(LS_J, 70, FLG_IDLE);
    rc(OFF_INT_FLAGS);
    wr(OFF_ROLE_CONTROL, 8'h01);
    wr(OFF_INT_FLAGS, 8'hFF);
    #1 `CHK(host_role_enable, 1'b1)
    ln(LS_SE0, 35, -1);
    ln(LS_J, 35, FLG_ATTACH);
    ln(LS_SE0, 35, FLG_RESET_DETACH);
    rc(OFF_INT_FLAGS);
    wr(OFF_ROLE_CONTROL, 8'h00);
    wr(OFF_INT_FLAGS, 8'hFF);
    $display("line events done");
    // Suspend: stall refused, activity pending until resume is raised
    ln(LS_J, 5, -1);
    wr(OFF_POWER_CONTROL, 8'h13);
    #1 `CHK(phy_ctrl, 4'b0111)
    ev(usbpi_evt_t'(11'h400), -1);
    ln(LS_K, 6, -1);
    act = 1'b1;
    #1 `CHK(sleep_block, 1'b1)
    rc(OFF_POWER_CONTROL);
    ln(LS_K, 30, FLG_RESUME);
    act = 1'b0;
    rc(OFF_POWER_CONTROL);
    rc(OFF_INT_FLAGS);
    `CHK(sleep_block, 1'b0)
    $display("suspend done");
    // Disable: no writes while the block settles
    wr(OFF_POWER_CONTROL, 8'h00);
    busy = 1'b1;
    #1 `CHK(phy_ctrl, 4'b0100)
    rc(OFF_POWER_CONTROL);
    repeat (12) @(posedge ref_clk);
    busy = 1'b0;
    rc(OFF_POWER_CONTROL);
    $display("disable done");
    complete_run();
  end
endmodule : test_usb_power_and_interrupt_flags
`default_nettype wire

// >>> testbench/usbpi_line_model.sv
// Cable-side model: drives both data lines to a commanded line state
`timescale 1ns/10ps
`default_nettype none
module usbpi_line_model (
  input  wire logic                   ref_clk,
  input  wire usbpi_pkg::usbpi_line_t line_cmd,
  output var logic                    usb_dp,
  output var logic                    usb_dm
);
  import usbpi_pkg::*;
  // Lines move mid-cycle, so the design's synchroniser sees them off its edge
  always @(posedge ref_clk) begin
    #37;
    usb_dp <= line_cmd == LS_J || line_cmd == LS_SE1;
    usb_dm <= line_cmd == LS_K || line_cmd == LS_SE1;
  end
  // Idle J on the cable from the start
  initial begin
    usb_dp = 1'b1;
    usb_dm = 1'b0;
  end
endmodule : usbpi_line_model
`default_nettype wire

// >>> testbench/usbpi_power_flags_checker.sv
// Checker: port-level assertions for the USB power and flag block
`timescale 1ns/10ps
`default_nettype none
module usbpi_power_flags_checker #(
  parameter int IDLE_CYC = 60
) (
  input wire logic                  ref_clk,
  input wire logic                  reset_n,
  input wire logic [7:0]            reg_addr,
  input wire logic [31:0]           reg_wdata,
  input wire logic                  reg_write,
  input wire logic                  reg_read,
  input wire logic [31:0]           reg_rdata,
  input wire logic                  usb_dp,
  input wire logic                  usb_dm,
  input wire usbpi_pkg::usbpi_evt_t engine_evt,
  input wire usbpi_pkg::usbpi_phy_t phy_ctrl,
  input wire logic                  host_role_enable,
  input wire logic                  sleep_block,
  input wire logic                  combined_interrupt_request,
  input wire logic                  token_fifo_advance
);
  import usbpi_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Decoded power accesses; token pulse kept in a reset-cleared flop
  wire logic pw = reg_write && reg_addr == OFF_POWER_CONTROL;
  wire logic pr = reg_read && reg_addr == OFF_POWER_CONTROL;
  logic      tok_q;
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) tok_q <= 1'b0;
    else tok_q <= engine_evt.token_done && phy_ctrl.usb_clk_enable;
  end
  AST_GATE: assert property (phy_ctrl.usb_clk_enable != phy_ctrl.xcvr_low_power)
    else $error("clock gate and low power disagree");
  AST_SUSP_WR: assert property (pw |=> phy_ctrl.usb_clk_enable ==
    ($past(reg_wdata[0]) && !$past(reg_wdata[1]))) else $error("clock gate not from write");
  AST_OFF_WR: assert property (pw |=> phy_ctrl.pins_owned == $past(reg_wdata[0])
    && phy_ctrl.analog_on == $past(reg_wdata[0])) else $error("pins not from enable");
  AST_OFF_HOLD: assert property (!phy_ctrl.pins_owned |->
    !phy_ctrl.usb_clk_enable && !combined_interrupt_request) else $error("active while off");
  AST_EN_RD: assert property (pr |=> reg_rdata[0] == $past(phy_ctrl.pins_owned))
    else $error("enable bit disagrees with pins");
  AST_BUSY: assert property (pr && phy_ctrl.pins_owned |=> reg_rdata[3])
    else $error("not ready clear while enabled");
  AST_RSVD: assert property (pr |=> reg_rdata[6:5] == 2'b00 && !reg_rdata[2])
    else $error("reserved power bit set");
  AST_HIGH: assert property (reg_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_RD_IDLE: assert property (!reg_read |=> reg_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  AST_ADV: assert property (token_fifo_advance |-> $past(reg_write) &&
    $past(reg_addr) == OFF_INT_FLAGS && $past(reg_wdata[3])) else $error("stray advance");
  AST_TOKEN: assert property ($past(tok_q) && !$past(reg_write) && reg_read &&
    reg_addr == OFF_INT_FLAGS |=> reg_rdata[3]) else $error("token flag missing");
  AST_SLEEP: assert property (sleep_block |-> phy_ctrl.pins_owned)
    else $error("sleep blocked while off");
  COV_ADV: cover property (token_fifo_advance);
  COV_IRQ: cover property (combined_interrupt_request);
  COV_SLP: cover property (sleep_block && phy_ctrl.xcvr_low_power);
endmodule : usbpi_power_flags_checker

bind usbpi_power_flags usbpi_power_flags_checker #(.IDLE_CYC(IDLE_CYC)) u_chk (
  .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .usb_dp(usb_dp),
  .usb_dm(usb_dm), .engine_evt(engine_evt), .phy_ctrl(phy_ctrl),
  .host_role_enable(host_role_enable), .sleep_block(sleep_block),
  .combined_interrupt_request(combined_interrupt_request),
  .token_fifo_advance(token_fifo_advance));
`default_nettype wire
